// ===== rtl/tpc_core.sv
/*
 timer counter core: 16-bit counter, prescaler, 1..8 capture/compare/pwm
 channels and an avalon-mm slave with waitrequest.
 assumes one bus clock; pins and clock inputs are asynchronous and are
 synchronised here; port logic outside muxes the pin by channel_pin_own.
*/
`timescale 1ns/100ps
`include "tpc_map.svh"
module tpc_core
    import tpc_pkg::*;
#(
    parameter int NCH = 2                          // channel count, 1..8
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         ce,
    input  tpc_av_req_t       av_req,
    output logic [31:0]       readdata,
    output logic              waitrequest,
    input  wire logic [NCH-1:0] channel_pin_in,
    input  wire logic         external_count_clock,
    input  wire logic         crystal_clock_in,
    output logic [NCH-1:0]    channel_pin_out,
    output logic [NCH-1:0]    channel_pin_oe,
    output logic [NCH-1:0]    channel_pin_own
);
    // whole module state
    typedef struct packed {
        tpc_core_t              c;
        tpc_chan_t [NCH-1:0]    ch;
    } tpc_state_t;

    tpc_state_t     st;        // registered state
    tpc_state_t     s;         // next state
    logic           acc;       // request taken this edge
    logic           wr;        // write taken this edge
    logic           stk;       // source tick before prescaler
    logic           tick;      // prescaled count enable
    logic           wrap;      // counter period end
    logic           cnt_wr;    // counter write taken
    logic [15:0]    emod;      // effective modulo
    logic [15:0]    cnt_n;     // next counter value
    logic           dn_n;      // next direction
    logic [7:0]     lim;       // prescaler end value
    logic [3:0]     csel;      // addressed channel
    logic           chit;      // channel address valid
    logic [NCH-1:0] match;     // compare match per channel
    logic [NCH-1:0] ic_hit;    // capture event per channel
    logic [NCH-1:0] act;       // channel function enabled
    logic [NCH-1:0] rise;      // synced pin rising
    logic [NCH-1:0] fall;      // synced pin falling

    // channel index of a byte address
    function automatic logic [3:0] tpc_chan_idx(input logic [7:0] a);
        logic [7:0] o;
        o = a - `TPC_OFS_CH_BASE;
        // offsets past the channel window get an index no channel has, so no alias
        return o[7] ? 4'hf : o[6:3];
    endfunction

    // address decode, used for read and write
    always_comb begin
        csel = tpc_chan_idx(av_req.address);
        chit = (av_req.address >= `TPC_OFS_CH_BASE) && (int'(csel) < NCH);
    end

    // next state
    always_comb begin
        s = st;
        // one wait cycle: request seen, answer on the next edge
        acc = (av_req.read || av_req.write) && !st.c.wreq;
        wr = acc && av_req.write;
        s.c.wreq = !((av_req.read || av_req.write) && st.c.wreq);
        cnt_wr = wr && (av_req.address == `TPC_OFS_CNT);

        // two flops before anything looks at the clock pins
        s.c.xs1 = crystal_clock_in;
        s.c.xs2 = st.c.xs1;
        s.c.xs3 = st.c.xs2;
        s.c.es1 = external_count_clock;
        s.c.es2 = st.c.es1;
        s.c.es3 = st.c.es2;

        // source choice; the external edge test relies on a slow clock
        case (st.c.src)
            TPC_SRC_NONE: stk = 1'b0;
            TPC_SRC_BUS:  stk = 1'b1;
            TPC_SRC_XTAL: stk = st.c.xs2 && !st.c.xs3;
            TPC_SRC_EXT:  stk = st.c.es2 && !st.c.es3;
            default:      stk = 1'b0;
        endcase

        // prescaler turns source ticks into a single-cycle enable
        lim = (8'h01 << st.c.ps) - 8'h01;
        tick = stk && (st.c.pre == lim[6:0]);
        if (tick) begin
            s.c.pre = 7'h00;
        end else if (stk) begin
            s.c.pre = st.c.pre + 7'h01;
        end

        // zero and all ones both mean full range
        emod = (st.c.modv == 16'h0000) ? `TPC_MOD_FREE : st.c.modv;

        // counter
        cnt_n = st.c.cnt;
        dn_n = st.c.down;
        wrap = 1'b0;
        if (tick) begin
            if (!st.c.center) begin
                dn_n = 1'b0;
                if (st.c.cnt >= emod) begin
                    cnt_n = 16'h0000;
                    wrap = 1'b1;
                end else begin
                    cnt_n = st.c.cnt + 16'h0001;
                end
            end else if (!st.c.down) begin
                if (st.c.cnt >= emod) begin
                    dn_n = 1'b1;
                    cnt_n = st.c.cnt - 16'h0001;
                end else begin
                    cnt_n = st.c.cnt + 16'h0001;
                end
            end else if (st.c.cnt == 16'h0000) begin
                dn_n = 1'b0;
                cnt_n = 16'h0001;
                wrap = 1'b1;
            end else begin
                cnt_n = st.c.cnt - 16'h0001;
            end
        end
        // any value written restarts counting from zero
        if (cnt_wr) begin
            cnt_n = 16'h0000;
            dn_n = 1'b0;
            s.c.pre = 7'h00;
        end
        s.c.cnt = cnt_n;
        s.c.down = dn_n;

        // control and modulo writes
        if (wr && (av_req.address == `TPC_OFS_CTRL)) begin
            s.c.ps = av_req.writedata[`TPC_CTRL_PS_LSB +: 3];
            s.c.src = tpc_src_t'(av_req.writedata[`TPC_CTRL_SRC_LSB +: 2]);
            s.c.center = av_req.writedata[`TPC_CTRL_CTR_BIT];
            // writing zero clears, writing one is ignored
            if (!av_req.writedata[`TPC_FLAG_BIT]) begin
                s.c.ovf = 1'b0;
            end
        end
        if (wr && (av_req.address == `TPC_OFS_MOD)) begin
            s.c.modv = av_req.writedata[15:0];
        end
        // set after clear, so an overflow in the clear cycle survives
        if (wrap) begin
            s.c.ovf = 1'b1;
        end

        // channels
        for (int i = 0; i < NCH; i++) begin
            s.ch[i].ps1 = channel_pin_in[i];
            s.ch[i].ps2 = st.ch[i].ps1;
            s.ch[i].ps3 = st.ch[i].ps2;
            rise[i] = st.ch[i].ps2 && !st.ch[i].ps3;
            fall[i] = !st.ch[i].ps2 && st.ch[i].ps3;
            // pin owned only with edge/level bits set and a source running
            act[i] = (st.ch[i].els != 2'b00) && (st.c.src != TPC_SRC_NONE);
            match[i] = tick && (cnt_n == st.ch[i].val);
            ic_hit[i] = 1'b0;

            // software writes first, hardware events below win
            if (wr && chit && (csel == 4'(i))) begin
                if (av_req.address[2]) begin
                    s.ch[i].val = av_req.writedata[15:0];
                end else begin
                    s.ch[i].els = av_req.writedata[`TPC_CH_ELS_LSB +: 2];
                    s.ch[i].mode = tpc_chmode_t'(av_req.writedata[`TPC_CH_MODE_LSB +: 2]);
                    if (!av_req.writedata[`TPC_FLAG_BIT]) begin
                        s.ch[i].flag = 1'b0;
                    end
                end
            end

            if (st.c.center) begin
                // mode bits ignored, all channels follow the up/down count
                if (match[i]) begin
                    s.ch[i].flag = 1'b1;
                    if (act[i]) begin
                        s.ch[i].out = dn_n ? !st.ch[i].els[0] : st.ch[i].els[0];
                    end
                end
            end else begin
                case (st.ch[i].mode)
                    TPC_CH_CAP: begin
                        ic_hit[i] = act[i] && (
                            ((st.ch[i].els == 2'b01) && rise[i]) ||
                            ((st.ch[i].els == 2'b10) && fall[i]) ||
                            ((st.ch[i].els == 2'b11) && (rise[i] || fall[i])));
                        if (ic_hit[i]) begin
                            s.ch[i].val = st.c.cnt;
                            s.ch[i].flag = 1'b1;
                        end
                    end
                    TPC_CH_CMP: begin
                        // flag works with no pin action, e.g. on the clock pin
                        if (match[i]) begin
                            s.ch[i].flag = 1'b1;
                            if (act[i]) begin
                                case (st.ch[i].els)
                                    2'b01:   s.ch[i].out = !st.ch[i].out;
                                    2'b10:   s.ch[i].out = 1'b0;
                                    2'b11:   s.ch[i].out = 1'b1;
                                    default: s.ch[i].out = st.ch[i].out;
                                endcase
                            end
                        end
                    end
                    default: begin
                        // shared counter gives every channel the same start
                        if (tick && (cnt_n == 16'h0000)) begin
                            s.ch[i].out = !st.ch[i].els[0];
                        end
                        // a match at zero wins, giving zero duty
                        if (match[i]) begin
                            s.ch[i].out = st.ch[i].els[0];
                            s.ch[i].flag = 1'b1;
                        end
                    end
                endcase
            end
            // drive enable: capture keeps the pin an input except in center mode
            s.ch[i].own = act[i];
            s.ch[i].oe = act[i] && (st.c.center || (st.ch[i].mode != TPC_CH_CAP));
        end

        // read data, latched on the request cycle; reads have no side effect
        if ((av_req.read || av_req.write) && st.c.wreq) begin
            case (av_req.address)
                `TPC_OFS_CTRL: s.c.rdata = {24'h000000, st.c.ovf, 1'b0,
                                            st.c.center, st.c.src, st.c.ps};
                `TPC_OFS_CNT:  s.c.rdata = {16'h0000, st.c.cnt};
                `TPC_OFS_MOD:  s.c.rdata = {16'h0000, st.c.modv};
                default: begin
                    if (chit && av_req.address[2]) begin
                        s.c.rdata = {16'h0000, st.ch[csel].val};
                    end else if (chit) begin
                        s.c.rdata = {24'h000000, st.ch[csel].flag, 1'b0,
                                     st.ch[csel].mode, st.ch[csel].els, 2'b00};
                    end else begin
                        s.c.rdata = 32'h00000000;    // unmapped reads zero
                    end
                end
            endcase
        end
    end

    // state register; reset leaves every function off
    always_ff @(posedge clock) begin
        if (rst) begin
            st <= '0;
            st.c.wreq <= 1'b1;
        end else if (ce) begin
            st <= s;
        end
    end

    // outputs straight from the state flops
    assign readdata = st.c.rdata;
    assign waitrequest = st.c.wreq;
    // one pin per channel
    for (genvar g = 0; g < NCH; g++) begin : g_pin
        assign channel_pin_out[g] = st.ch[g].out;
        assign channel_pin_oe[g] = st.ch[g].oe;
        assign channel_pin_own[g] = st.ch[g].own;
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_cnt_wr;
        ce && cnt_wr;
    endsequence

    sequence s_free_step;
        ce && tick && !cnt_wr && !st.c.center;
    endsequence

    property p_cnt_reset;
        s_cnt_wr |=> (st.c.cnt == 16'h0000) && !st.c.down;
    endproperty
    a_cnt_reset: assert property (p_cnt_reset)
        else $error("counter not cleared by write");

    property p_free_run;
        s_free_step ##0 (st.c.modv == 16'h0000) && (st.c.cnt == 16'hfffe)
            |=> (st.c.cnt == 16'hffff) ##1 (st.c.cnt == 16'hffff || st.c.cnt == 16'h0000);
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("free-running count skipped full range");

    property p_wrap;
        s_free_step ##0 (st.c.cnt == emod) |=> (st.c.cnt == 16'h0000) && st.c.ovf;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap did not clear counter and set overflow");

    property p_turn;
        ce && tick && !cnt_wr && st.c.center && !st.c.down && (st.c.cnt == emod)
            |=> st.c.down && (st.c.cnt == $past(st.c.cnt) - 16'h0001);
    endproperty
    a_turn: assert property (p_turn)
        else $error("center count did not turn at modulo");

    property p_read_keeps;
        ce && acc && av_req.read && !tick |=> st.c.cnt == $past(st.c.cnt);
    endproperty
    a_read_keeps: assert property (p_read_keeps)
        else $error("counter read disturbed count");

    // a synchronised external edge gives one tick, never a run of them
    property p_ext_sync;
        ce && (st.c.src == TPC_SRC_EXT) && stk && !wr |=> !stk;
    endproperty
    a_ext_sync: assert property (p_ext_sync)
        else $error("external edge gave more than one tick");

    property p_gpio;
        ce && (st.c.src == TPC_SRC_NONE) |=> channel_pin_own == '0;
    endproperty
    a_gpio: assert property (p_gpio)
        else $error("pin kept while timer disabled");

    property p_capture;
        ce && ic_hit[NCH-1]
            |=> st.ch[NCH-1].flag && (st.ch[NCH-1].val == $past(st.c.cnt));
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture lost counter value or flag");

    property p_pwm_edge;
        ce && !st.c.center && st.ch[0].mode[1] && (st.ch[0].els == 2'b10) && tick
            && (cnt_n == 16'h0000) && (st.ch[0].val != 16'h0000)
            |=> channel_pin_out[0] ##0 channel_pin_own[0];
    endproperty
    a_pwm_edge: assert property (p_pwm_edge)
        else $error("edge pwm did not rise at period start");

    property p_oc_toggle;
        ce && !st.c.center && (st.ch[0].mode == TPC_CH_CMP) && (st.ch[0].els == 2'b01)
            && act[0] && match[0] |=> channel_pin_out[0] == !$past(channel_pin_out[0]);
    endproperty
    a_oc_toggle: assert property (p_oc_toggle)
        else $error("compare toggle missing");

    // one up step per tick below the modulo; with a_wrap the period is modulo plus one
    property p_count_step;
        s_free_step ##0 (st.c.cnt < emod) |=> st.c.cnt == $past(st.c.cnt) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("edge count did not step by one");

    // center step on channel 0 set high-true
    sequence s_center_step;
        ce && tick && !cnt_wr && st.c.center && act[0] && (st.ch[0].els == 2'b10);
    endsequence

    property p_center_on;
        s_center_step ##0 st.c.down && (st.c.cnt != 16'h0000)
            && (st.c.cnt == st.ch[0].val + 16'h0001) |=> channel_pin_out[0];
    endproperty
    a_center_on: assert property (p_center_on)
        else $error("center output not set on down match");

    property p_center_off;
        s_center_step ##0 !st.c.down && (st.c.cnt < emod)
            && (st.c.cnt + 16'h0001 == st.ch[0].val) |=> !channel_pin_out[0];
    endproperty
    a_center_off: assert property (p_center_off)
        else $error("center output not cleared on up match");

    // outside center mode a capture channel owns its pin but never drives it
    property p_cap_input;
        ce && !st.c.center && (st.ch[NCH-1].mode == TPC_CH_CAP) && act[NCH-1]
            |=> channel_pin_own[NCH-1] && !channel_pin_oe[NCH-1];
    endproperty
    a_cap_input: assert property (p_cap_input)
        else $error("capture channel drove its pin");
endmodule

// ===== rtl/tpc_map.svh
/*
 register map, field positions and reset values of the timer counter core.
 assumes byte addressing on an 8-bit avalon address, one 32-bit word per register.
*/
// Behaviour
// - edge pwm period is modulo plus one
// - channel value sets edge pwm transition point
// - period end and transition raise event flags
// - edge pwm channels share period, aligned starts
// - center pwm period twice modulo, pulse twice value
// - center counter counts up, then down, repeats
// - center output: active down-match, inactive up-match
// - modulo zero or all ones runs free
// - counter reads never disturb counting
// - any counter write clears the counter
// - center mode disables capture, compare, edge pwm
// - otherwise each channel picks its own mode
// - one pin per channel, one to eight
// - unused pins return to general port logic
// - after reset nothing enabled, pins general
// - source select: none, bus, crystal, external
// - external clock synchronised by bus clock
// - external-clock channel keeps software timer use
// - capture edge copies counter, sets flag
// - compare match sets flag, does pin action
// - edge pwm: active from zero, inactive from match
// - overflow flag set on wrap to zero
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH
`define TPC_OFS_CTRL     8'h00
`define TPC_OFS_CNT      8'h04
`define TPC_OFS_MOD      8'h08
`define TPC_OFS_CH_BASE  8'h10
`define TPC_CTRL_PS_LSB  0
`define TPC_CTRL_SRC_LSB 3
`define TPC_CTRL_CTR_BIT 5
`define TPC_FLAG_BIT     7
`define TPC_CH_ELS_LSB   2
`define TPC_CH_MODE_LSB  4
`define TPC_MOD_FREE     16'hffff
`define TPC_MOD_RST      16'h0000
`endif

// ===== rtl/tpc_pkg.sv
/*
 types of the timer counter core: bus request carrier, enumerations and state.
 assumes tpc_map.svh is compiled with it.
*/
package tpc_pkg;
    // avalon request bundle from the master
    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } tpc_av_req_t;

    // count source choice
    typedef enum logic [1:0] {
        TPC_SRC_NONE = 2'b00,
        TPC_SRC_BUS  = 2'b01,
        TPC_SRC_XTAL = 2'b10,
        TPC_SRC_EXT  = 2'b11
    } tpc_src_t;

    // channel function
    typedef enum logic [1:0] {
        TPC_CH_CAP  = 2'b00,
        TPC_CH_CMP  = 2'b01,
        TPC_CH_PWM  = 2'b10,
        TPC_CH_PWMB = 2'b11
    } tpc_chmode_t;

    // per-channel state
    typedef struct packed {
        tpc_chmode_t mode;
        logic [1:0]  els;
        logic        flag;
        logic [15:0] val;
        logic        ps1;
        logic        ps2;
        logic        ps3;
        logic        out;
        logic        oe;
        logic        own;
    } tpc_chan_t;

    // shared counter and bus state
    typedef struct packed {
        tpc_src_t    src;
        logic [2:0]  ps;
        logic        center;
        logic        ovf;
        logic [15:0] cnt;
        logic [15:0] modv;
        logic        down;
        logic [6:0]  pre;
        logic        xs1;
        logic        xs2;
        logic        xs3;
        logic        es1;
        logic        es2;
        logic        es3;
        logic        wreq;
        logic [31:0] rdata;
    } tpc_core_t;
endpackage

// ===== tb/tpc_pin_model.sv
/*
 far-side model of the timer core: channel pins and both count clocks.
 assumes the bench changes run_clk and pin_stim right after a rising edge.
*/
`timescale 1ns/100ps
module tpc_pin_model #(
    parameter int NCH = 2                  // channel count
) (
    input  wire logic           clock,
    input  wire logic           run_clk,
    input  wire logic [NCH-1:0] pin_stim,
    input  wire logic [NCH-1:0] pin_out,
    input  wire logic [NCH-1:0] pin_oe,
    output logic [NCH-1:0]      pin_level,
    output logic                ext_clk,
    output logic                xtal_clk
);
    logic half_r;                          // phase of the quarter-rate divider

    // a driven pin follows the timer, a sensed pin follows the outside world
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            pin_level[i] = pin_oe[i] ? pin_out[i] : pin_stim[i];
        end
    end

    // count clock: four bus cycles a period, parked low outside a burst
    always_ff @(posedge clock) begin
        if (!run_clk) begin
            half_r  <= 1'b0;
            ext_clk <= 1'b0;
        end else begin
            half_r <= ~half_r;
            if (half_r) begin
                ext_clk <= ~ext_clk;
            end
        end
    end

    // the crystal-related source shares the generator; the bench picks one
    assign xtal_clk = ext_clk;
endmodule

// ===== tb/test_timer_pwm_counter_core.sv
/*
 self-checking bench of the timer core: avalon tasks, pwm, compare, capture
 and count-source scenarios.
 assumes tpc_pkg and tpc_map.svh come first; clock enable stays high.
*/
`timescale 1ns/100ps
`include "tpc_map.svh"
module test_timer_pwm_counter_core
    import tpc_pkg::*;
;
    localparam int NCH = 2;                // two channels show the shared period
    logic           clock;
    logic           rst;
    tpc_av_req_t    av_req;
    logic [31:0]    readdata;
    logic           waitrequest;
    logic [NCH-1:0] pin_level;
    logic [NCH-1:0] pin_stim;
    logic [NCH-1:0] pin_out;
    logic [NCH-1:0] pin_oe;
    logic [NCH-1:0] pin_own;
    logic           run_clk;
    logic           ext_clk;
    logic           xtal_clk;
    logic [31:0]    rd;                    // data of the last read
    logic [31:0]    rd2;                   // first captured value
    int             n_fail;
    int             cmp_count;
    int             hi;                    // cycles matching a pin pattern
    int             cyc = 0;               // free cycle count
    int             t0;
    tpc_src_t       src_tab[3] = '{TPC_SRC_NONE, TPC_SRC_XTAL, TPC_SRC_EXT};
    int             cmp_hi[4] = '{0, 45, 0, 90};

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) cyc <= cyc + 1;

    tpc_core #(.NCH(NCH)) dut (
        .clock(clock), .rst(rst), .ce(1'b1), .av_req(av_req),
        .readdata(readdata), .waitrequest(waitrequest),
        .channel_pin_in(pin_level), .external_count_clock(ext_clk),
        .crystal_clock_in(xtal_clk), .channel_pin_out(pin_out),
        .channel_pin_oe(pin_oe), .channel_pin_own(pin_own)
    );

    tpc_pin_model #(.NCH(NCH)) pins (
        .clock(clock), .run_clk(run_clk), .pin_stim(pin_stim), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_level(pin_level), .ext_clk(ext_clk), .xtal_clk(xtal_clk)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one transfer, held until waitrequest is sampled low
    task automatic av_xfer(input logic is_wr, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        @(posedge clock);
        av_req <= '{read: !is_wr, write: is_wr, address: adr, writedata: wd};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rd = readdata;
        av_req <= '0;
        if (waitrequest !== 1'b0) begin
            n_fail++;
            give_verdict();
        end
    endtask

    task automatic av_write(input logic [7:0] adr, input logic [31:0] wd);
        av_xfer(1'b1, adr, wd);
    endtask

    task automatic av_check(input logic [7:0] adr, input logic [31:0] exp);
        av_xfer(1'b0, adr, 32'h0);
        check(rd, exp);
    endtask

    // counts cycles in which the pins show the given pattern
    task automatic meas(input logic [NCH-1:0] pat, input int n);
        hi = 0;
        repeat (n) begin
            @(posedge clock);
            if (pin_out === pat) hi++;
        end
    endtask

    task automatic do_reset();
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
    endtask

    initial begin
        rst = 1'b1;
        av_req = '0;
        pin_stim = '0;
        run_clk = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        // reset state: registers clear, pins left to the port logic
        av_check(`TPC_OFS_CTRL, 32'h0);
        av_check(`TPC_OFS_MOD, 32'h0);
        av_check(8'h80, 32'h0);
        check({30'h0, pin_own}, 32'h0);
        // edge pwm: ch0 high-true from 5, ch1 low-true from 3, modulo 8
        av_write(`TPC_OFS_MOD, 32'h8);
        av_write(`TPC_OFS_CH_BASE + 8'h4, 32'h5);
        av_write(`TPC_OFS_CH_BASE, 32'h28);
        av_write(`TPC_OFS_CH_BASE + 8'hc, 32'h3);
        av_write(`TPC_OFS_CH_BASE + 8'h8, 32'h24);
        av_write(`TPC_OFS_CTRL, 32'h08);
        repeat (20) @(posedge clock);
        // counter reads run alongside; the waveform must not shift
        fork
            meas(2'b01, 90);
            repeat (10) av_xfer(1'b0, `TPC_OFS_CNT, 32'h0);
        join
        check(hi, 30);
        meas(2'b11, 90);
        check(hi, 20);
        meas(2'b10, 90);
        check(hi, 40);
        av_check(`TPC_OFS_CTRL, 32'h88);
        av_check(`TPC_OFS_CH_BASE, 32'ha8);
        av_check(`TPC_OFS_CH_BASE + 8'h8, 32'ha4);
        // compare actions: toggle, clear, set
        for (int e = 1; e < 4; e++) begin
            do_reset();
            av_write(`TPC_OFS_MOD, 32'h8);
            av_write(`TPC_OFS_CH_BASE + 8'h4, 32'h3);
            av_write(`TPC_OFS_CH_BASE, 32'h10 | (e << 2));
            av_write(`TPC_OFS_CTRL, 32'h08);
            repeat (20) @(posedge clock);
            meas(2'b01, 90);
            check(hi, cmp_hi[e]);
            av_check(`TPC_OFS_CH_BASE, 32'h90 | (e << 2));
        end
        // center pwm: ch1 left in capture mode still follows the pwm
        do_reset();
        av_write(`TPC_OFS_MOD, 32'h8);
        av_write(`TPC_OFS_CH_BASE + 8'h4, 32'h5);
        av_write(`TPC_OFS_CH_BASE + 8'hc, 32'h5);
        av_write(`TPC_OFS_CH_BASE, 32'h08);
        av_write(`TPC_OFS_CH_BASE + 8'h8, 32'h04);
        av_write(`TPC_OFS_CTRL, 32'h28);
        repeat (40) @(posedge clock);
        meas(2'b01, 160);
        check(hi, 100);
        meas(2'b10, 160);
        check(hi, 60);
        check({30'h0, pin_oe}, 32'h3);
        av_xfer(1'b0, `TPC_OFS_CNT, 32'h0);
        check({31'h0, rd <= 32'h8}, 32'h1);
        // capture: two rising edges a whole number of periods apart
        do_reset();
        av_write(`TPC_OFS_MOD, 32'h8);
        av_write(`TPC_OFS_CH_BASE + 8'h8, 32'h04);
        av_write(`TPC_OFS_CTRL, 32'h08);
        repeat (20) @(posedge clock);
        pin_stim <= 2'b10;
        t0 = cyc;
        repeat (8) @(posedge clock);
        pin_stim <= 2'b00;
        av_xfer(1'b0, `TPC_OFS_CH_BASE + 8'hc, 32'h0);
        rd2 = rd;
        while (cyc < t0 + 36) @(posedge clock);
        pin_stim <= 2'b10;
        repeat (8) @(posedge clock);
        av_check(`TPC_OFS_CH_BASE + 8'hc, rd2);
        check({31'h0, rd2 <= 32'h8}, 32'h1);
        av_check(`TPC_OFS_CH_BASE + 8'h8, 32'h84);
        check({30'h0, pin_own}, 32'h2);
        check({30'h0, pin_oe}, 32'h0);
        // count sources: none, crystal, external; 20 rising edges a burst, divide by two
        for (int s = 0; s < 3; s++) begin
            do_reset();
            av_write(`TPC_OFS_CH_BASE + 8'h4, 32'h5);
            av_write(`TPC_OFS_CH_BASE, 32'h10);
            av_write(`TPC_OFS_CTRL, {27'h0, src_tab[s], 3'h1});
            @(posedge clock);
            run_clk <= 1'b1;
            repeat (80) @(posedge clock);
            run_clk <= 1'b0;
            repeat (10) @(posedge clock);
            av_check(`TPC_OFS_CNT, (s > 0) ? 32'h0000000a : 32'h00000000);
            av_check(`TPC_OFS_CH_BASE, (s > 0) ? 32'h90 : 32'h10);
            check({30'h0, pin_own}, 32'h0);
            av_write(`TPC_OFS_CNT, 32'h1234);
            av_check(`TPC_OFS_CNT, 32'h0);
        end
        // free run: modulo zero wraps only after the full 16-bit range
        do_reset();
        av_write(`TPC_OFS_CTRL, 32'h08);
        repeat (65500) @(posedge clock);
        av_check(`TPC_OFS_CTRL, 32'h08);
        repeat (60) @(posedge clock);
        av_check(`TPC_OFS_CTRL, 32'h88);
        give_verdict();
    end
endmodule
